//--- rtl/cca_pkg.sv
// Register indices, field positions and reset values of the counter array
package cca_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] MODE0_IDX   = 8'hDA;
  localparam logic [7:0] MODE1_IDX   = 8'hDB;
  localparam logic [7:0] CNT_LO_IDX  = 8'hE9;
  localparam logic [7:0] CNT_HI_IDX  = 8'hF9;
  localparam logic [7:0] CMP0_LO_IDX = 8'hEA;
  localparam logic [7:0] CMP1_LO_IDX = 8'hEB;
  localparam logic [7:0] CMP0_HI_IDX = 8'hFA;
  localparam logic [7:0] CMP1_HI_IDX = 8'hFB;
  localparam logic [7:0] STATUS_IDX  = 8'hD8;
  localparam logic [7:0] CLEAR_IDX   = 8'hC0;
  localparam logic [7:0] ENABLE_IDX  = 8'hC1;

  // Index field of the byte address
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // Mode register fields
  localparam int MODULE_IRQ_ENABLE   = 0;
  localparam int PULSE_WIDTH_MODE    = 1;
  localparam int MATCH_TOGGLE_ENABLE = 2;
  localparam int MATCH_FLAG_ENABLE   = 3;
  localparam int CAPTURE_FALL_ENABLE = 4;
  localparam int CAPTURE_RISE_ENABLE = 5;
  localparam int COMPARE_ENABLE      = 6;
  localparam logic [7:0] MODE_MASK   = 8'h7F;

  // Reset values
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [7:0]  CMP_RST  = 8'h00;

  // Low byte value that precedes a rollover
  localparam logic [7:0] LOW_BYTE_TOP = 8'hFF;

  // Number of compare/capture modules
  localparam int NUM_MODULES = 2;

endpackage

//--- rtl/counter_array_module_mode_control.sv
// Counter array: free-running counter, two compare/capture modules, AHB-Lite
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module counter_array_module_mode_control
  import cca_pkg::*;
#(
  parameter int MODULES = NUM_MODULES
)(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Module pins
  input  wire logic [MODULES-1:0]  modulePinIn,
  output logic [MODULES-1:0]       modulePinOut,
  output logic [MODULES-1:0]       modulePinOe,
  // Interrupt
  output logic                     irq
);

  typedef struct packed {
    logic [15:0]              counter;
    logic [MODULES-1:0][7:0]  mode;
    logic [MODULES-1:0][7:0]  cmpLo;
    logic [MODULES-1:0][7:0]  cmpHi;
    logic [MODULES-1:0]       flags;
    logic [MODULES-1:0]       intEn;
    logic [MODULES-1:0]       pinPrev;
    logic [MODULES-1:0]       pinOut;
    logic [MODULES-1:0]       pinOe;
    logic                     wrPend;
    logic [7:0]               wrIdx;
    logic [7:0]               rdata;
    logic                     ready;
    logic                     irq;
  } state_t;

  state_t s;
  state_t next_s;

  logic [MODULES-1:0] riseEdge;
  logic [MODULES-1:0] fallEdge;
  logic [MODULES-1:0] capHit;
  logic [MODULES-1:0] matchHit;
  logic [MODULES-1:0] pwmOn;
  logic               accept;
  logic               rollover;

  assign accept   = hsel & htrans[1] & hready;
  assign rollover = (s.counter[7:0] == LOW_BYTE_TOP);

  // Per-module edge, capture and match detection
  genvar g;
  generate
    for (g = 0; g < MODULES; g++)
    begin : gen_mod
      assign riseEdge[g] = modulePinIn[g] & ~s.pinPrev[g];
      assign fallEdge[g] = ~modulePinIn[g] & s.pinPrev[g];
      assign capHit[g] =
        (riseEdge[g] & s.mode[g][CAPTURE_RISE_ENABLE]) |
        (fallEdge[g] & s.mode[g][CAPTURE_FALL_ENABLE]);
      assign pwmOn[g] = s.mode[g][PULSE_WIDTH_MODE] &
                        s.mode[g][COMPARE_ENABLE];
      assign matchHit[g] = s.mode[g][COMPARE_ENABLE] & ~pwmOn[g] &
                           (s.counter == {s.cmpHi[g], s.cmpLo[g]});
    end
  endgenerate

  // Register read mux
  function automatic logic [7:0] readReg(input state_t st,
                                         input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      MODE0_IDX:   v = st.mode[0];
      MODE1_IDX:   v = st.mode[1];
      CNT_LO_IDX:  v = st.counter[7:0];
      CNT_HI_IDX:  v = st.counter[15:8];
      CMP0_LO_IDX: v = st.cmpLo[0];
      CMP1_LO_IDX: v = st.cmpLo[1];
      CMP0_HI_IDX: v = st.cmpHi[0];
      CMP1_HI_IDX: v = st.cmpHi[1];
      STATUS_IDX:  v = 8'({st.flags});
      ENABLE_IDX:  v = 8'({st.intEn});
      default:     v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.ready = 1'b1;
    next_s.counter = s.counter + 16'h0001;
    next_s.pinPrev = modulePinIn;
    next_s.wrPend = accept & hwrite;
    next_s.wrIdx = haddr[IDX_MSB:IDX_LSB];
    // Software writes in the data phase
    if (s.wrPend)
    begin
      case (s.wrIdx)
        MODE0_IDX:   next_s.mode[0] = hwdata[7:0] & MODE_MASK;
        MODE1_IDX:   next_s.mode[1] = hwdata[7:0] & MODE_MASK;
        CNT_LO_IDX:  next_s.counter[7:0] = hwdata[7:0];
        CNT_HI_IDX:  next_s.counter[15:8] = hwdata[7:0];
        CMP0_LO_IDX: next_s.cmpLo[0] = hwdata[7:0];
        CMP1_LO_IDX: next_s.cmpLo[1] = hwdata[7:0];
        CMP0_HI_IDX: next_s.cmpHi[0] = hwdata[7:0];
        CMP1_HI_IDX: next_s.cmpHi[1] = hwdata[7:0];
        CLEAR_IDX:   next_s.flags = s.flags & ~hwdata[MODULES-1:0];
        ENABLE_IDX:  next_s.intEn = hwdata[MODULES-1:0];
        default:     next_s.flags = next_s.flags;
      endcase
    end
    // Hardware events win over software writes
    for (int i = 0; i < MODULES; i++)
    begin
      next_s.pinOe[i] = pwmOn[i] |
        (s.mode[i][COMPARE_ENABLE] & s.mode[i][MATCH_TOGGLE_ENABLE]);
      if (capHit[i])
      begin
        next_s.cmpLo[i] = s.counter[7:0];
        next_s.cmpHi[i] = s.counter[15:8];
        next_s.flags[i] = 1'b1;
      end
      if (matchHit[i] & s.mode[i][MATCH_FLAG_ENABLE])
        next_s.flags[i] = 1'b1;
      if (matchHit[i] & s.mode[i][MATCH_FLAG_ENABLE] &
          s.mode[i][MATCH_TOGGLE_ENABLE])
        next_s.pinOut[i] = ~s.pinOut[i];
      if (pwmOn[i])
      begin
        next_s.pinOut[i] = (s.counter[7:0] >= s.cmpLo[i]);
        if (rollover)
          next_s.cmpLo[i] = s.cmpHi[i];
      end
    end
    next_s.irq = 1'b0;
    for (int i = 0; i < MODULES; i++)
      next_s.irq = next_s.irq | (next_s.flags[i] & next_s.intEn[i] &
                                 next_s.mode[i][MODULE_IRQ_ENABLE]);
    if (accept & ~hwrite)
      next_s.rdata = readReg(next_s, haddr[IDX_MSB:IDX_LSB]);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign hreadyout    = s.ready;
  assign hresp        = 1'b0;
  assign hrdata       = {24'h000000, s.rdata};
  assign modulePinOut = s.pinOut;
  assign modulePinOe  = s.pinOe;
  assign irq          = s.irq;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic noCntWrite;
  assign noCntWrite = ~(s.wrPend & ((s.wrIdx == CNT_LO_IDX) |
                                    (s.wrIdx == CNT_HI_IDX)));

  counter_run_a: assert property (
    rst_b && noCntWrite |=> s.counter == $past(s.counter) + 16'h0001)
    else $error("counter did not advance by one");

  reset_zero_a: assert property (
    $past(!rst_b) |-> (s.mode == '0) && (s.counter == CNT_RST) && !irq)
    else $error("state not zero after reset");

  high_write_a: assert property (
    s.wrPend && s.wrIdx == CNT_HI_IDX |=>
      s.counter[15:8] == $past(hwdata[7:0]))
    else $error("counter high byte write lost");

  low_write_a: assert property (
    s.wrPend && s.wrIdx == CNT_LO_IDX |=>
      s.counter[7:0] == $past(hwdata[7:0]))
    else $error("counter low byte write lost");

  // mode write over both bus phases
  sequence modeAddr;
    accept && hwrite && haddr[IDX_MSB:IDX_LSB] == MODE0_IDX;
  endsequence
  mode_write_a: assert property (
    modeAddr ##1 1'b1 |=> s.mode[0] == ($past(hwdata[7:0]) & MODE_MASK))
    else $error("mode write not masked");

  sequence mode1Addr;
    accept && hwrite && haddr[IDX_MSB:IDX_LSB] == MODE1_IDX;
  endsequence
  mode1_write_a: assert property (
    mode1Addr ##1 1'b1 |=> s.mode[1] == ($past(hwdata[7:0]) & MODE_MASK))
    else $error("second mode write not masked");

  sequence highRead;
    accept && !hwrite && haddr[IDX_MSB:IDX_LSB] == CNT_HI_IDX;
  endsequence
  high_read_a: assert property (
    highRead |=> hrdata == {24'h000000, s.counter[15:8]})
    else $error("counter high byte read wrong");

  sequence lowRead;
    accept && !hwrite && haddr[IDX_MSB:IDX_LSB] == CNT_LO_IDX;
  endsequence
  low_read_a: assert property (
    lowRead |=> hrdata == {24'h000000, s.counter[7:0]})
    else $error("counter low byte read wrong");

  for (genvar k = 0; k < MODULES; k++)
  begin : gen_chk
    sequence fallSeen;
      fallEdge[k] && s.mode[k][CAPTURE_FALL_ENABLE];
    endsequence
    sequence capStored;
      {s.cmpHi[k], s.cmpLo[k]} == $past(s.counter) && s.flags[k];
    endsequence
    cmp_gate_a: assert property (
      !s.mode[k][COMPARE_ENABLE] && !capHit[k] && !s.wrPend |=>
        s.flags[k] == $past(s.flags[k]))
      else $error("flag set with compare disabled");
    fall_capture_a: assert property (
      fallSeen |=> capStored)
      else $error("falling edge capture missed");
    rise_capture_a: assert property (
      riseEdge[k] && s.mode[k][CAPTURE_RISE_ENABLE] |=> capStored)
      else $error("rising edge capture missed");
    match_flag_a: assert property (
      matchHit[k] && s.mode[k][MATCH_FLAG_ENABLE] |=> s.flags[k])
      else $error("match did not set event flag");
    pin_toggle_a: assert property (
      matchHit[k] && s.mode[k][MATCH_FLAG_ENABLE] &&
      s.mode[k][MATCH_TOGGLE_ENABLE] |=>
        modulePinOut[k] != $past(modulePinOut[k]))
      else $error("match did not toggle pin");
    pwm_level_a: assert property (
      pwmOn[k] |=> modulePinOut[k] ==
        ($past(s.counter[7:0]) >= $past(s.cmpLo[k])) && modulePinOe[k])
      else $error("pulse width level wrong");
    pwm_reload_a: assert property (
      pwmOn[k] && rollover && !capHit[k] |=>
        s.cmpLo[k] == $past(s.cmpHi[k]))
      else $error("low compare byte not reloaded");
    pwm_quiet_a: assert property (
      pwmOn[k] && !capHit[k] && !s.wrPend |=>
        s.flags[k] == $past(s.flags[k]))
      else $error("flag changed in pulse width mode");
    mode_top_a: assert property (
      s.mode[k][7] == 1'b0)
      else $error("mode top bit set");
    flag_sticky_a: assert property (
      s.flags[k] && !(s.wrPend && s.wrIdx == CLEAR_IDX) |=> s.flags[k])
      else $error("event flag dropped");
    flag_clear_a: assert property (
      s.wrPend && s.wrIdx == CLEAR_IDX && hwdata[k] && !capHit[k] &&
      !(matchHit[k] && s.mode[k][MATCH_FLAG_ENABLE]) |=> !s.flags[k])
      else $error("event flag not cleared");
    pin_hold_a: assert property (
      !pwmOn[k] && !(matchHit[k] && s.mode[k][MATCH_FLAG_ENABLE] &&
      s.mode[k][MATCH_TOGGLE_ENABLE]) |=>
        modulePinOut[k] == $past(modulePinOut[k]))
      else $error("pin changed without match");
    pin_enable_a: assert property (
      rst_b |=> modulePinOe[k] == $past(pwmOn[k] |
        (s.mode[k][COMPARE_ENABLE] & s.mode[k][MATCH_TOGGLE_ENABLE])))
      else $error("pin drive enable wrong");
    fall_quiet_a: assert property (
      fallEdge[k] && !s.mode[k][CAPTURE_FALL_ENABLE] && !s.wrPend &&
      !pwmOn[k] |=> {s.cmpHi[k], s.cmpLo[k]} ==
        $past({s.cmpHi[k], s.cmpLo[k]}))
      else $error("falling edge captured while disabled");
    rise_quiet_a: assert property (
      riseEdge[k] && !s.mode[k][CAPTURE_RISE_ENABLE] && !s.wrPend &&
      !pwmOn[k] |=> {s.cmpHi[k], s.cmpLo[k]} ==
        $past({s.cmpHi[k], s.cmpLo[k]}))
      else $error("rising edge captured while disabled");
  end

  irq_gate_a: assert property (
    ##1 irq == |(s.flags & s.intEn &
      {s.mode[1][MODULE_IRQ_ENABLE], s.mode[0][MODULE_IRQ_ENABLE]}))
    else $error("interrupt output mismatch");

endmodule

`default_nettype wire

//--- dv/pin_partner.sv
// Outside pin model: resolves each module pin from both drivers
`timescale 1ns/1ps
`default_nettype none
module pin_partner
  import cca_pkg::*;
(
  // Design side
  input  wire logic [NUM_MODULES-1:0] pinOut,
  input  wire logic [NUM_MODULES-1:0] pinOe,
  // Outside driver
  input  wire logic [NUM_MODULES-1:0] drive,
  // Resolved level
  output logic [NUM_MODULES-1:0]      level
);
  always_comb level = (pinOe & pinOut) | (~pinOe & drive);
endmodule
`default_nettype wire

//--- dv/counter_array_module_mode_control_tb_top.sv
// Self-checking bench of the counter array block
`timescale 1ns/1ps
`default_nettype none
module counter_array_module_mode_control_tb_top
  import cca_pkg::*;
;
  logic        clock, rst_b, hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, seed, r;
  logic [1:0]  htrans, pOut, pOe, pIn, drv;
  logic [2:0]  hsize;
  logic [7:0]  v;
  int          fail_count, compares, hi;
  logic [7:0]  cm [6] = '{8'h10, 8'h10, 8'h20, 8'h20, 8'h30, 8'h30};
  logic        cl [6] = '{1, 0, 1, 0, 1, 0};
  logic        ce [6] = '{0, 1, 1, 0, 1, 1};
  logic [7:0]  mdl [2];

  counter_array_module_mode_control dut (.clock(clock), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .modulePinIn(pIn),
    .modulePinOut(pOut), .modulePinOe(pOe), .irq(irq));
  pin_partner partner (.pinOut(pOut), .pinOe(pOe), .drive(drv),
    .level(pIn));

  always #12.5 clock = ~clock;

  function logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task bus(input logic [7:0] i, input logic w, input logic [7:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, i, 2'h0};
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    v = hrdata[7:0];
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    bus(i, 1'b1, d);
  endtask

  task rdc(input string n, input logic [7:0] i, input logic [7:0] e);
    bus(i, 1'b0, 8'h00);
    chk(n, {24'h0, v}, {24'h0, e});
  endtask

  task give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    give_verdict();
  end

  initial
  begin
    clock = 0; rst_b = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; drv = 0; seed = 32'h2E26;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rdc("cnt hi rst", CNT_HI_IDX, CNT_RST[15:8]);
    rdc("mode0 rst", MODE0_IDX, MODE_RST);
    rdc("mode1 rst", MODE1_IDX, MODE_RST);
    wr(CNT_LO_IDX, 8'h00);
    wr(CNT_HI_IDX, 8'h5A);
    rdc("cnt hi", CNT_HI_IDX, 8'h5A);
    bus(CNT_LO_IDX, 1'b0, 8'h00);
    chk("cnt lo", {31'h0, v < 8'h10}, 1);
    rdc("unmapped", 8'h00, 8'h00);
    chk("hresp", {31'h0, hresp}, 0);
    for (int i = 0; i < 2; i++)
    begin
      r = rnd();
      mdl[i] = r[7:0] & MODE_MASK;
      wr(8'(MODE0_IDX + i), r[7:0]);
      rdc("mode rw", 8'(MODE0_IDX + i), mdl[i]);
    end
    // Compare enable and match flag set on both modules, toggle on module 1 only
    wr(ENABLE_IDX, 8'h03);
    wr(MODE0_IDX, 8'h48);
    wr(MODE1_IDX, 8'h4C);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'(CMP0_LO_IDX + i), 8'h40);
      wr(8'(CMP0_HI_IDX + i), 8'h00);
    end
    wr(CNT_HI_IDX, 8'h00);
    wr(CNT_LO_IDX, 8'h00);
    repeat (100) @(posedge clock);
    rdc("match flags", STATUS_IDX, 8'h03);
    @(negedge clock);
    chk("irq masked", {31'h0, irq}, 0);
    chk("toggle pin", {30'h0, pOe[1], pOut[1]}, 3);
    wr(MODE0_IDX, 8'h49);
    repeat (2) @(negedge clock);
    chk("irq on", {31'h0, irq}, 1);
    wr(CLEAR_IDX, 8'h03);
    rdc("cleared", STATUS_IDX, 8'h00);
    @(negedge clock);
    chk("irq off", {31'h0, irq}, 0);
    wr(MODE0_IDX, 8'h09);
    wr(MODE1_IDX, 8'h00);
    wr(CNT_LO_IDX, 8'h00);
    repeat (100) @(posedge clock);
    rdc("no compare", STATUS_IDX, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      wr(MODE0_IDX, cm[k]);
      wr(CLEAR_IDX, 8'h01);
      drv[0] <= cl[k];
      repeat (4) @(posedge clock);
      rdc("capture", STATUS_IDX, {7'h0, ce[k]});
    end
    r = rnd() & 32'hFF;
    wr(CMP0_LO_IDX, r[7:0]);
    wr(CMP0_HI_IDX, r[7:0]);
    wr(MODE0_IDX, 8'h42);
    repeat (300) @(posedge clock);
    hi = 0;
    repeat (256)
    begin
      @(negedge clock);
      hi += int'(pOut[0] & pOe[0]);
    end
    chk("pwm duty", hi, 256 - r);
    give_verdict();
  end
endmodule
`default_nettype wire
